// ---- verilog/iipi_pkg.sv ----
// iipi_pkg: constants of the isolated input port with interrupts
// assumes a 10 MHz ref_clk and a 32-byte I/O window
package iipi_pkg;
  localparam int NCH = 128;
  localparam int NIRQ = 16;
  localparam int GRP = 16;
  localparam int AW = 32;
  localparam int DW = 32;
  localparam int OFF_W = 5;
  localparam logic [4:0] OFF_DIN0 = 5'h00;
  localparam logic [4:0] OFF_DIN1 = 5'h04;
  localparam logic [4:0] OFF_DIN2 = 5'h08;
  localparam logic [4:0] OFF_DIN3 = 5'h0c;
  localparam logic [4:0] OFF_FLT = 5'h10;
  localparam logic [4:0] OFF_IEN = 5'h14;
  localparam logic [4:0] OFF_EDGE = 5'h18;
  localparam logic [4:0] OFF_STAT = 5'h1c;
  localparam int CODE_W = 4;
  localparam logic [3:0] FLT_RST = 4'h0;
  localparam logic [3:0] FLT_MAX = 4'h8;
  localparam logic [15:0] IEN_RST = 16'h0000;
  localparam logic [15:0] EDGE_RST = 16'h0000;
  localparam logic [15:0] STAT_RST = 16'h0000;
  localparam logic [1:0] FLT_HITS = 2'h3;
  localparam int PRESC_W = 8;
  localparam int CLK_MHZ = 10;
  localparam int RESP_US = 200;
  localparam int RESP_CYC = RESP_US * CLK_MHZ;
endpackage

// ---- verilog/iipi_chan_if.sv ----
// iipi_chan_if: channel data between top, filter and edge detector
// assumes all users run on ref_clk
`timescale 1ns/1ps
`default_nettype none
interface iipi_chan_if;
  logic [127:0] raw;
  logic [127:0] clean;
  logic [3:0] code;
  logic [15:0] edgeSel;
  logic [15:0] edgeEvt;
  modport top (output raw, output code, output edgeSel,
               input clean, input edgeEvt);
  modport flt (input raw, input code, output clean);
  modport edg (input clean, input edgeSel, output edgeEvt);
endinterface
`default_nettype wire

// ---- verilog/iipi_filter.sv ----
// iipi_filter: anti-chatter filter on every input channel
// assumes raw data already synchronised to ref_clk
`timescale 1ns/1ps
`default_nettype none
module iipi_filter (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic ce,
  iipi_chan_if.flt ch
);
  import iipi_pkg::*;
  logic [PRESC_W-1:0] presc_q;
  logic [1:0] hit_q [NCH];
  logic [127:0] clean_q;
  logic [8:0] mask;
  logic tick;

  assign mask = (9'h1 << ch.code) - 9'h1;
  assign tick = ((presc_q & mask[7:0]) == 8'h00);
  assign ch.clean = clean_q;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      presc_q <= '0;
    end else if (ce) begin
      presc_q <= presc_q + 8'h01;
    end
  end

  // code 0 passes data straight, else four agreeing ticks
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      clean_q <= '0;
      for (int i = 0; i < NCH; i++) hit_q[i] <= 2'h0;
    end else if (ce) begin
      for (int i = 0; i < NCH; i++) begin
        if (ch.code == 4'h0) begin
          clean_q[i] <= ch.raw[i];
          hit_q[i] <= 2'h0;
        end else if (ch.raw[i] == clean_q[i]) begin
          hit_q[i] <= 2'h0;
        end else if (tick) begin
          if (hit_q[i] == FLT_HITS) begin
            clean_q[i] <= ch.raw[i];
            hit_q[i] <= 2'h0;
          end else begin
            hit_q[i] <= hit_q[i] + 2'h1;
          end
        end
      end
    end
  end
endmodule
`default_nettype wire

// ---- verilog/iipi_edge.sv ----
// iipi_edge: edge events on the interrupt-capable channels
// assumes clean data from the filter on the same clock
`timescale 1ns/1ps
`default_nettype none
module iipi_edge (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic ce,
  iipi_chan_if.edg ch
);
  import iipi_pkg::*;
  logic [15:0] prev_q;
  logic [15:0] rise;
  logic [15:0] fall;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      prev_q <= '0;
    end else if (ce) begin
      prev_q <= ch.clean[NIRQ-1:0];
    end
  end

  assign rise = ch.clean[NIRQ-1:0] & ~prev_q;
  assign fall = ~ch.clean[NIRQ-1:0] & prev_q;
  // select 0 rising, 1 falling
  assign ch.edgeEvt = ce ? ((rise & ~ch.edgeSel) | (fall & ch.edgeSel))
                       : 16'h0000;
endmodule
`default_nettype wire

// ---- verilog/iipi_top.sv ----
// iipi_top: 128-channel isolated input port with edge interrupts
// assumes a plain register port on ref_clk and a host-set I/O base
//
// Design decisions made here: strobed register access and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module iipi_top (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [iipi_pkg::NCH-1:0] pinLevel,
  input wire logic [iipi_pkg::AW-1:0] ioBase,
  input wire logic [iipi_pkg::AW-1:0] addr,
  input wire logic [iipi_pkg::DW-1:0] wrData,
  input wire logic wrStb,
  input wire logic rdStb,
  output logic [iipi_pkg::DW-1:0] rdData,
  output logic irq,
  output logic intaNOut,
  output logic intaNOeN
);
  import iipi_pkg::*;

  iipi_chan_if ch ();

  logic [127:0] sync1_q;
  logic [127:0] sync2_q;
  logic [127:0] sync3_q;
  logic [127:0] level_q;
  logic [3:0] flt_q;
  logic [15:0] ien_q;
  logic [15:0] edge_q;
  logic [15:0] stat_q;
  logic [15:0] stat_d;
  logic [31:0] rdData_q;
  logic [31:0] rdVal;
  logic hit;
  logic [4:0] off;
  logic wrHit;
  logic rdHit;

  ////////////////////////////////////////////////////////////////////
  // input synchroniser, negative logic

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      sync1_q <= '1;
      sync2_q <= '1;
      sync3_q <= '1;
    end else if (ce) begin
      sync1_q <= pinLevel;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
    end
  end

  // a bit counts once stages two and three agree
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      level_q <= '1;
    end else if (ce) begin
      for (int i = 0; i < NCH; i++) begin
        if (sync2_q[i] == sync3_q[i]) level_q[i] <= sync3_q[i];
      end
    end
  end

  assign ch.raw = ~level_q;
  assign ch.code = flt_q;
  assign ch.edgeSel = edge_q;

  iipi_filter i_iipi_filter (
    .ref_clk(ref_clk),
    .rst(rst),
    .ce(ce),
    .ch(ch.flt)
  );

  iipi_edge i_iipi_edge (
    .ref_clk(ref_clk),
    .rst(rst),
    .ce(ce),
    .ch(ch.edg)
  );

  ////////////////////////////////////////////////////////////////////
  // register port decode

  assign hit = (addr[AW-1:OFF_W] == ioBase[AW-1:OFF_W]) &&
               (addr[1:0] == 2'h0);
  assign off = addr[OFF_W-1:0];
  assign wrHit = ce && wrStb && hit;
  assign rdHit = ce && rdStb && hit;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      flt_q <= FLT_RST;
    end else if (wrHit && off == OFF_FLT) begin
      // codes above the limit are stored as FLT_MAX, so flt_q never exceeds code 8
      if (wrData[CODE_W-1:0] > FLT_MAX) flt_q <= FLT_MAX;
      else flt_q <= wrData[CODE_W-1:0];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ien_q <= IEN_RST;
    end else if (wrHit && off == OFF_IEN) begin
      ien_q <= wrData[NIRQ-1:0];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      edge_q <= EDGE_RST;
    end else if (wrHit && off == OFF_EDGE) begin
      edge_q <= wrData[NIRQ-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////
  // sticky status, write one to clear, set wins

  always_comb begin
    stat_d = stat_q;
    if (wrHit && off == OFF_STAT) stat_d = stat_d & ~wrData[NIRQ-1:0];
    stat_d = stat_d | ch.edgeEvt;
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      stat_q <= STAT_RST;
    end else if (ce) begin
      stat_q <= stat_d;
    end
  end

  assign irq = |(stat_q & ien_q);
  assign intaNOut = 1'b0;
  assign intaNOeN = ~irq;

  ////////////////////////////////////////////////////////////////////
  // read data, valid only in the cycle after the strobe

  always_comb begin
    unique case (off)
      OFF_DIN0: rdVal = ch.clean[31:0];
      OFF_DIN1: rdVal = ch.clean[63:32];
      OFF_DIN2: rdVal = ch.clean[95:64];
      OFF_DIN3: rdVal = ch.clean[127:96];
      OFF_FLT: rdVal = {28'h0000000, flt_q};
      OFF_IEN: rdVal = {16'h0000, ien_q};
      OFF_EDGE: rdVal = {16'h0000, edge_q};
      OFF_STAT: rdVal = {16'h0000, stat_q};
      default: rdVal = 32'h00000000;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rdData_q <= '0;
    end else if (ce) begin
      rdData_q <= rdHit ? rdVal : 32'h00000000;
    end
  end

  assign rdData = rdData_q;

  ////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  logic [10:0] lagCnt_q;
  logic [127:0] rawPrev_q;
  localparam int RESP_LIM = RESP_CYC;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      lagCnt_q <= '0;
      rawPrev_q <= '0;
    end else if (ce) begin
      rawPrev_q <= ch.raw;
      if (ch.raw != rawPrev_q || ch.raw == ch.clean) lagCnt_q <= '0;
      else lagCnt_q <= lagCnt_q + 11'h001;
    end
  end

  din_low_a: assert property (
    rdHit && off == OFF_DIN0 |=> rdData == $past(ch.clean[31:0])
  ) else $error("low input word read wrong");

  din_word1_a: assert property (
    rdHit && off == OFF_DIN1 |=> rdData == $past(ch.clean[63:32])
  ) else $error("second input word read wrong");

  din_word2_a: assert property (
    rdHit && off == OFF_DIN2 |=> rdData == $past(ch.clean[95:64])
  ) else $error("third input word read wrong");

  din_high_a: assert property (
    rdHit && off == OFF_DIN3 |=> rdData == $past(ch.clean[127:96])
  ) else $error("high input word read wrong");

  neg_logic_a: assert property (
    ce && sync2_q[0] == sync3_q[0] && flt_q == 4'h0
    ##1 ce && flt_q == 4'h0
    |=> ch.clean[0] == !$past(sync3_q[0], 2)
  ) else $error("input polarity wrong");

  ien_gate_a: assert property (
    ien_q == 16'h0000 |-> !irq && intaNOeN
  ) else $error("interrupt with all enables off");

  wr_ien_a: assert property (
    wrHit && off == OFF_IEN |=> ien_q == $past(wrData[NIRQ-1:0])
  ) else $error("enable write lost");

  rise_set_a: assert property (
    ce && $past(ce) && !edge_q[0] && $rose(ch.clean[0]) |=> stat_q[0]
  ) else $error("rising edge missed");

  fall_set_a: assert property (
    ce && $past(ce) && edge_q[2] && $fell(ch.clean[2]) |=> stat_q[2]
  ) else $error("falling edge missed");

  edge_mask_a: assert property (
    ce && $past(ce) && edge_q[2] && $rose(ch.clean[2]) |-> !ch.edgeEvt[2]
  ) else $error("event on unselected edge");

  wr_edge_a: assert property (
    wrHit && off == OFF_EDGE |=> edge_q == $past(wrData[NIRQ-1:0])
  ) else $error("edge select write lost");

  edge_rd_a: assert property (
    rdHit && off == OFF_EDGE |=> rdData == {16'h0000, $past(edge_q)}
  ) else $error("edge select read wrong");

  irq_raise_a: assert property (
    ce && |(ch.edgeEvt & ien_q) && !(wrHit && off == OFF_IEN)
    |=> irq && !intaNOeN
  ) else $error("enabled event gave no request");

  set_wins_a: assert property (
    ce && |ch.edgeEvt |=> (stat_q & $past(ch.edgeEvt)) == $past(ch.edgeEvt)
  ) else $error("event lost in status");

  w1c_clear_a: assert property (
    wrHit && off == OFF_STAT && ch.edgeEvt == 16'h0000
    |=> (stat_q & $past(wrData[NIRQ-1:0])) == 16'h0000
  ) else $error("status bit not cleared");

  stat_rd_a: assert property (
    rdHit && off == OFF_STAT |=> rdData == {16'h0000, $past(stat_q)}
  ) else $error("status read wrong");

  flt_bypass_a: assert property (
    ce && flt_q == 4'h0 |=> ch.clean == $past(ch.raw)
  ) else $error("filter off did not pass data");

  flt_rd_a: assert property (
    rdHit && off == OFF_FLT |=> rdData == {28'h0000000, $past(flt_q)}
  ) else $error("filter code read wrong");

  resp_time_a: assert property (
    lagCnt_q < RESP_LIM
  ) else $error("input change too slow");

  flt_clamp_a: assert property (
    flt_q <= FLT_MAX
  ) else $error("filter code above limit");

  rd_window_a: assert property (
    ce && !rdHit |=> rdData == 32'h00000000
  ) else $error("read data outside its cycle");

  ce_freeze_a: assert property (
    !ce |=> $stable(stat_q) && $stable(ien_q) && $stable(edge_q)
            && $stable(flt_q) && $stable(rdData)
  ) else $error("state moved with clock enable low");

  unmapped_rd_a: assert property (
    ce && rdStb && !hit |=> rdData == 32'h00000000
  ) else $error("read outside window answered");

  ////////////////////////////////////////////////////////////////////
  // scenario covers

  irq_cycle_c: cover property (!irq ##1 irq ##[1:20] !irq);
  flt_change_c: cover property (flt_q != 4'h0 && $changed(ch.clean));
  stat_clear_c: cover property (
    wrHit && off == OFF_STAT && |stat_q ##1 stat_q == 16'h0000
  );
  fall_irq_c: cover property (edge_q[2] && ch.edgeEvt[2]);
  ce_hold_c: cover property (!ce ##1 ce);
endmodule
`default_nettype wire

// ---- tb/iipi_host.sv ----
// iipi_host: host side model issuing register port cycles
// assumes ref_clk shared with the device and a 32-bit data path
`timescale 1ns/1ps
`default_nettype none
module iipi_host (
  input wire logic ref_clk,
  output logic [iipi_pkg::AW-1:0] addr,
  output logic [iipi_pkg::DW-1:0] wrData,
  output logic wrStb,
  output logic rdStb,
  input wire logic [iipi_pkg::DW-1:0] rdData
);
  import iipi_pkg::*;
  initial begin
    addr = 32'hffffffff;
    wrData = 32'hffffffff;
    wrStb = 1'h0;
    rdStb = 1'h0;
  end
  ////////////////////////////////////////////////////////////////////////
  // one-cycle strobes; released lines show inverted values
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    addr <= a;
    wrData <= d;
    wrStb <= 1'h1;
    @(posedge ref_clk);
    wrStb <= 1'h0;
    addr <= ~a;
    wrData <= ~d;
  endtask
  task automatic rd(input logic [31:0] a, output logic [31:0] d);
    @(posedge ref_clk);
    addr <= a;
    rdStb <= 1'h1;
    @(posedge ref_clk);
    rdStb <= 1'h0;
    addr <= ~a;
    @(negedge ref_clk);
    d = rdData;
  endtask
endmodule
`default_nettype wire

// ---- tb/test_isolated_input_port_irq.sv ----
// test_isolated_input_port_irq: register level tests of iipi_top
// assumes iipi_host drives the register port on the same clock
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin bad_count++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module test_isolated_input_port_irq;
  import iipi_pkg::*;
  localparam logic [31:0] BASE = 32'h00000300;
  localparam logic [127:0] PAT = 128'h00000001_00010000_80000000_000000ff;
  logic ref_clk, rst, ce, irq, intaNOut, intaNOeN, wrStb, rdStb;
  logic [NCH-1:0] pinLevel;
  logic [DW-1:0] addr, wrData, rdData, v;
  int bad_count, cmp_count;
  iipi_top i_iipi_top (.ref_clk(ref_clk), .rst(rst), .ce(ce),
    .pinLevel(pinLevel), .ioBase(BASE), .addr(addr), .wrData(wrData),
    .wrStb(wrStb), .rdStb(rdStb), .rdData(rdData), .irq(irq),
    .intaNOut(intaNOut), .intaNOeN(intaNOeN));
  iipi_host i_iipi_host (.ref_clk(ref_clk), .addr(addr), .wrData(wrData),
    .wrStb(wrStb), .rdStb(rdStb), .rdData(rdData));
  initial begin
    ref_clk = 1'h0;
    forever #50 ref_clk = ~ref_clk;
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic test_done;
    $display("mismatches %0d compares %0d", bad_count, cmp_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic rchk(input logic [4:0] off, input logic [31:0] e);
    i_iipi_host.rd(BASE + {27'h0, off}, v);
    `CHK(v, e)
  endtask
  task automatic wreg(input logic [4:0] off, input logic [31:0] d);
    i_iipi_host.wr(BASE + {27'h0, off}, d);
  endtask
  task automatic pin(input int i, input logic l);
    @(posedge ref_clk);
    pinLevel[i] <= l;
    repeat (8) @(posedge ref_clk);
  endtask
  task automatic irqchk(input logic e);
    @(negedge ref_clk);
    `CHK({irq, intaNOeN, intaNOut}, {e, ~e, 1'h0})
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge ref_clk);
    bad_count++;
    test_done();
  end
  initial begin
    rst = 1'h1;
    ce = 1'h1;
    pinLevel = {NCH{1'h1}};
    repeat (16) @(posedge ref_clk);
    rst <= 1'h0;
    rchk(OFF_STAT, 32'h0);
    rchk(OFF_FLT, 32'h0);
    irqchk(1'h0);
    i_iipi_host.wr(32'h00000414, 32'h0000ffff);
    i_iipi_host.rd(32'h00000414, v);
    `CHK(v, 32'h0)
    rchk(OFF_IEN, 32'h0);
    // all terminals high read as zero, then a pattern pulled low
    for (int w = 0; w < 4; w++)
      rchk(OFF_DIN0 + 5'(4 * w), 32'h0);
    @(posedge ref_clk);
    pinLevel <= ~PAT;
    repeat (8) @(posedge ref_clk);
    for (int w = 0; w < 4; w++)
      rchk(OFF_DIN0 + 5'(4 * w), PAT[32 * w +: 32]);
    rchk(OFF_STAT, 32'h000000ff);
    irqchk(1'h0);
    @(posedge ref_clk);
    pinLevel <= {NCH{1'h1}};
    repeat (8) @(posedge ref_clk);
    rchk(OFF_STAT, 32'h000000ff);
    wreg(OFF_STAT, 32'h000000ff);
    rchk(OFF_STAT, 32'h0);
    // ch0 on rising data, ch2 on falling data, ch1 disabled
    wreg(OFF_IEN, 32'h00000005);
    wreg(OFF_EDGE, 32'h00000004);
    rchk(OFF_EDGE, 32'h00000004);
    pin(0, 1'h0);
    irqchk(1'h1);
    pin(2, 1'h0);
    rchk(OFF_STAT, 32'h00000001);
    wreg(OFF_STAT, 32'h00000001);
    irqchk(1'h0);
    pin(2, 1'h1);
    rchk(OFF_STAT, 32'h00000004);
    irqchk(1'h1);
    wreg(OFF_IEN, 32'h00000001);
    irqchk(1'h0);
    wreg(OFF_STAT, 32'h00000004);
    pin(1, 1'h0);
    rchk(OFF_STAT, 32'h00000002);
    irqchk(1'h0);
    @(posedge ref_clk);
    pinLevel <= {NCH{1'h1}};
    wreg(OFF_IEN, 32'h0);
    // clock enable low: a write is ignored
    @(posedge ref_clk);
    ce <= 1'h0;
    wreg(OFF_IEN, 32'h0000ffff);
    @(posedge ref_clk);
    ce <= 1'h1;
    rchk(OFF_IEN, 32'h0);
    // filter at its slowest: short pulse dropped, step seen in time
    wreg(OFF_FLT, 32'h00000009);
    rchk(OFF_FLT, {28'h0, FLT_MAX});
    @(posedge ref_clk);
    pinLevel[3] <= 1'h0;
    repeat (40) @(posedge ref_clk);
    pinLevel[3] <= 1'h1;
    repeat (RESP_CYC) @(posedge ref_clk);
    rchk(OFF_DIN0, 32'h0);
    @(posedge ref_clk);
    pinLevel[3] <= 1'h0;
    repeat (RESP_CYC) @(posedge ref_clk);
    rchk(OFF_DIN0, 32'h00000008);
    test_done();
  end
endmodule
`default_nettype wire
